// *** logic/hesb_pkg.sv ***
// Constants and register map of the host error status bank.
// Notes on behaviour
// - Bits 0 to 3 of register one set when zones 1 to 4 leave their limits.
// - Zone 1 and 2 events blocked in deep sleep only when their mask bit is set.
// - Zone 3 and 4 events are never blocked by any sleep state.
// - Bits 4 and 5 follow the regulator hot inputs, always blocked in deep sleep.
// - Register two bit n-1 sets when analog input n (1..8) leaves its window.
// - Register three bit n-9 sets when analog input n (9..16) leaves its window.
// - Analog inputs 1 to 11 and 15 always blocked in deep sleep.
// - Analog inputs 12 to 14 blocked in deep sleep only when their mask bit is set.
// - Analog input 16 is never blocked by any sleep state.
// - Register four bits 2 and 3 follow termination inputs, blocked in deep sleep.
// - Register four bit 4 sets on processor one core voltage mismatch, deep-sleep blocked.
// - Register four bit 5 sets on processor two core voltage mismatch, deep-sleep blocked.
// - Register four bit 6 sets on diode one fault, optionally blocked in deep sleep.
// - Register four bit 7 sets on diode two fault, optionally blocked in deep sleep.
// - Writing one clears a flag; writing zero leaves it alone.
// - Flags stay set after the condition goes; clearing fails while an unblocked condition persists.
// - The summary bit is high whenever any flag in the four registers is set.
// - Sleep state comes from a software register; optional blocking from mask registers.
package hesb_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_THERMAL_REG = 8'h48;
    localparam logic [7:0] OFF_ANALOG_LOW = 8'h49;
    localparam logic [7:0] OFF_ANALOG_HIGH = 8'h4a;
    localparam logic [7:0] OFF_FAULT = 8'h4b;
    localparam logic [7:0] OFF_SLEEP_STATE = 8'h60;
    localparam logic [7:0] OFF_MASK_THERMAL = 8'h61;
    localparam logic [7:0] OFF_MASK_ANALOG_HIGH = 8'h62;
    localparam logic [7:0] OFF_MASK_FAULT = 8'h63;
    localparam logic [7:0] OFF_GLOBAL_STATUS = 8'h64;

    // ------------------------------------------------------------
    // Reset values and sleep state encodings
    // ------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int SLEEP_W = 2;
    localparam logic [1:0] SLEEP_S0 = 2'h0;
    localparam logic [1:0] SLEEP_S1 = 2'h1;
    localparam logic [1:0] SLEEP_S3 = 2'h2;
    localparam logic [1:0] SLEEP_S45 = 2'h3;
    localparam logic [7:0] GSTAT_HOST_ERR = 8'h01;

    // ------------------------------------------------------------
    // Per-register masks: implemented bits, bits always blocked in
    // deep sleep, and bits blocked only when software asks for it.
    // ------------------------------------------------------------
    localparam logic [7:0] KEEP_THERMAL = 8'h3f;
    localparam logic [7:0] UNCOND_THERMAL = 8'h30;
    localparam logic [7:0] OPT_THERMAL = 8'h03;
    localparam logic [7:0] KEEP_ANALOG_LOW = 8'hff;
    localparam logic [7:0] UNCOND_ANALOG_LOW = 8'hff;
    localparam logic [7:0] OPT_ANALOG_LOW = 8'h00;
    localparam logic [7:0] KEEP_ANALOG_HIGH = 8'hff;
    localparam logic [7:0] UNCOND_ANALOG_HIGH = 8'h47;
    localparam logic [7:0] OPT_ANALOG_HIGH = 8'h38;
    localparam logic [7:0] KEEP_FAULT = 8'hfc;
    localparam logic [7:0] UNCOND_FAULT = 8'h3c;
    localparam logic [7:0] OPT_FAULT = 8'hc0;

    // ------------------------------------------------------------
    // Whole state of the bank
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] thermal_flags;
        logic [7:0] analog_low_flags;
        logic [7:0] analog_high_flags;
        logic [7:0] fault_flags;
        logic [1:0] sleep_state;
        logic [7:0] mask_thermal;
        logic [7:0] mask_analog_high;
        logic [7:0] mask_fault;
        logic [7:0] rd_data;
        logic summary;
    } hesb_state_s;

endpackage

// *** logic/hesb_host_error_status_bank.sv ***
// Host error status bank: four sticky write-one-to-clear flag registers with sleep masking.
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`default_nettype none
module hesb_host_error_status_bank
    import hesb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    output wire logic [7:0] reg_rd_data,
    // Thermal and regulator events
    input wire logic [3:0] zone_limit_event,
    input wire logic regulator_one_hot_input,
    input wire logic regulator_two_hot_input,
    // Analog window events, bit n-1 for channel n
    input wire logic [15:0] analog_input_window_event,
    // Fault events
    input wire logic termination_one_input,
    input wire logic termination_two_input,
    input wire logic core_voltage_one_mismatch,
    input wire logic core_voltage_two_mismatch,
    input wire logic diode_one_fault,
    input wire logic diode_two_fault,
    // Summary
    output wire logic host_error_summary
);

    // ------------------------------------------------------------
    // Flag update helper
    // ------------------------------------------------------------
    // The set term is ORed after the clear so an event never loses
    // against a clear in the same cycle.
    function automatic logic [7:0] hesb_update(
        input logic [7:0] flags,
        input logic [7:0] ev,
        input logic [7:0] clr,
        input logic [7:0] keep,
        input logic [7:0] uncond,
        input logic [7:0] opt,
        input logic [7:0] umask,
        input logic deep
    );
        logic [7:0] blk;
        blk = deep ? (uncond | (opt & umask)) : 8'h00;
        return ((flags & ~clr) | (ev & ~blk)) & keep;
    endfunction

    hesb_state_s q_r;
    hesb_state_s q_nxt;
    logic deep_sleep;
    logic wr_thermal;
    logic wr_analog_low;
    logic wr_analog_high;
    logic wr_fault;
    logic [7:0] ev_thermal;
    logic [7:0] ev_fault;

    // ------------------------------------------------------------
    // Event vectors
    // ------------------------------------------------------------
    // Unused reserved positions are fed zero and also trimmed by keep.
    assign ev_thermal = {2'b00, regulator_two_hot_input, regulator_one_hot_input,
                         zone_limit_event};
    assign ev_fault = {diode_two_fault, diode_one_fault, core_voltage_two_mismatch,
                       core_voltage_one_mismatch, termination_two_input,
                       termination_one_input, 2'b00};

    // ------------------------------------------------------------
    // Address decode for clears
    // ------------------------------------------------------------
    assign wr_thermal = reg_wr_en && (reg_addr == OFF_THERMAL_REG);
    assign wr_analog_low = reg_wr_en && (reg_addr == OFF_ANALOG_LOW);
    assign wr_analog_high = reg_wr_en && (reg_addr == OFF_ANALOG_HIGH);
    assign wr_fault = reg_wr_en && (reg_addr == OFF_FAULT);

    // S3 and S4/5 are the deep states; S0 and S1 block nothing here.
    assign deep_sleep = (q_r.sleep_state == SLEEP_S3) || (q_r.sleep_state == SLEEP_S45);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        q_nxt.rd_data = 8'h00;
        // Sticky flags with write-one-to-clear and sleep blocking.
        q_nxt.thermal_flags = hesb_update(q_r.thermal_flags, ev_thermal,
            wr_thermal ? reg_wr_data : 8'h00, KEEP_THERMAL, UNCOND_THERMAL,
            OPT_THERMAL, q_r.mask_thermal, deep_sleep);
        q_nxt.analog_low_flags = hesb_update(q_r.analog_low_flags,
            analog_input_window_event[7:0], wr_analog_low ? reg_wr_data : 8'h00,
            KEEP_ANALOG_LOW, UNCOND_ANALOG_LOW, OPT_ANALOG_LOW, 8'h00,
            deep_sleep);
        q_nxt.analog_high_flags = hesb_update(q_r.analog_high_flags,
            analog_input_window_event[15:8], wr_analog_high ? reg_wr_data : 8'h00,
            KEEP_ANALOG_HIGH, UNCOND_ANALOG_HIGH, OPT_ANALOG_HIGH,
            q_r.mask_analog_high, deep_sleep);
        q_nxt.fault_flags = hesb_update(q_r.fault_flags, ev_fault,
            wr_fault ? reg_wr_data : 8'h00, KEEP_FAULT, UNCOND_FAULT, OPT_FAULT,
            q_r.mask_fault, deep_sleep);
        // Sleep state and mask registers written by software.
        if (reg_wr_en) begin
            case (reg_addr)
                OFF_SLEEP_STATE: begin
                    q_nxt.sleep_state = reg_wr_data[SLEEP_W-1:0];
                end
                OFF_MASK_THERMAL: begin
                    q_nxt.mask_thermal = reg_wr_data & OPT_THERMAL;
                end
                OFF_MASK_ANALOG_HIGH: begin
                    q_nxt.mask_analog_high = reg_wr_data & OPT_ANALOG_HIGH;
                end
                OFF_MASK_FAULT: begin
                    q_nxt.mask_fault = reg_wr_data & OPT_FAULT;
                end
                default: begin
                end
            endcase
        end
        // Summary follows the new flags so it never lags them.
        q_nxt.summary = |{q_nxt.thermal_flags, q_nxt.analog_low_flags,
                          q_nxt.analog_high_flags, q_nxt.fault_flags};
        // Read data stands only in the cycle after the strobe; unmapped reads give zero.
        if (reg_rd_en) begin
            case (reg_addr)
                OFF_THERMAL_REG: begin
                    q_nxt.rd_data = q_r.thermal_flags;
                end
                OFF_ANALOG_LOW: begin
                    q_nxt.rd_data = q_r.analog_low_flags;
                end
                OFF_ANALOG_HIGH: begin
                    q_nxt.rd_data = q_r.analog_high_flags;
                end
                OFF_FAULT: begin
                    q_nxt.rd_data = q_r.fault_flags;
                end
                OFF_SLEEP_STATE: begin
                    q_nxt.rd_data = {{(8-SLEEP_W){1'b0}}, q_r.sleep_state};
                end
                OFF_MASK_THERMAL: begin
                    q_nxt.rd_data = q_r.mask_thermal;
                end
                OFF_MASK_ANALOG_HIGH: begin
                    q_nxt.rd_data = q_r.mask_analog_high;
                end
                OFF_MASK_FAULT: begin
                    q_nxt.rd_data = q_r.mask_fault;
                end
                OFF_GLOBAL_STATUS: begin
                    q_nxt.rd_data = q_r.summary ? GSTAT_HOST_ERR : 8'h00;
                end
                default: begin
                    q_nxt.rd_data = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r.thermal_flags <= FLAGS_RESET;
            q_r.analog_low_flags <= FLAGS_RESET;
            q_r.analog_high_flags <= FLAGS_RESET;
            q_r.fault_flags <= FLAGS_RESET;
            q_r.sleep_state <= SLEEP_S0;
            q_r.mask_thermal <= MASK_RESET;
            q_r.mask_analog_high <= MASK_RESET;
            q_r.mask_fault <= MASK_RESET;
            q_r.rd_data <= 8'h00;
            q_r.summary <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign reg_rd_data = q_r.rd_data;
    assign host_error_summary = q_r.summary;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_zone3_never_masked: assert property (
        zone_limit_event[2] |=> q_r.thermal_flags[2])
        else $error("zone three event did not set its flag");

    chk_zone1_opt_mask: assert property (
        (deep_sleep && q_r.mask_thermal[0] && !q_r.thermal_flags[0] && !reg_wr_en)
        |=> !q_r.thermal_flags[0])
        else $error("masked zone one event set its flag");

    chk_zone1_sets_awake: assert property (
        (zone_limit_event[0] && !deep_sleep) |=> q_r.thermal_flags[0])
        else $error("zone one event lost while awake");

    chk_regulator_deep_block: assert property (
        (deep_sleep && !q_r.thermal_flags[4] && !reg_wr_en) |=> !q_r.thermal_flags[4])
        else $error("regulator flag set in deep sleep");

    chk_analog16_unmasked: assert property (
        analog_input_window_event[15] |=> q_r.analog_high_flags[7])
        else $error("analog sixteen event did not set its flag");

    chk_analog_low_deep: assert property (
        (deep_sleep && q_r.analog_low_flags == 8'h00 && !reg_wr_en)
        |=> q_r.analog_low_flags == 8'h00)
        else $error("low analog flag set in deep sleep");

    chk_fault_core_one: assert property (
        (core_voltage_one_mismatch && !deep_sleep) |=> q_r.fault_flags[4])
        else $error("core voltage one mismatch not flagged");

    chk_write_one_clears: assert property (
        (wr_analog_low && reg_wr_data[0] && !analog_input_window_event[0])
        |=> !q_r.analog_low_flags[0])
        else $error("write of one did not clear the flag");

    chk_write_zero_keeps: assert property (
        (wr_analog_low && !reg_wr_data[3] && q_r.analog_low_flags[3])
        |=> q_r.analog_low_flags[3])
        else $error("write of zero cleared the flag");

    chk_set_beats_clear: assert property (
        (wr_thermal && reg_wr_data[2] && zone_limit_event[2])
        |=> q_r.thermal_flags[2])
        else $error("clear won over a live event");

    chk_summary_tracks: assert property (
        host_error_summary == (|{q_r.thermal_flags, q_r.analog_low_flags,
                                q_r.analog_high_flags, q_r.fault_flags}))
        else $error("summary disagrees with flags");

    chk_reserved_zero: assert property (
        q_r.thermal_flags[7:6] == 2'b00 && q_r.fault_flags[1:0] == 2'b00)
        else $error("reserved bit is set");

    chk_sleep_write: assert property (
        (reg_wr_en && reg_addr == OFF_SLEEP_STATE)
        |=> q_r.sleep_state == $past(reg_wr_data[SLEEP_W-1:0]))
        else $error("sleep state not taken from write");

    chk_read_one_cycle: assert property (
        (reg_rd_en && reg_addr == OFF_FAULT) |=> reg_rd_data == $past(q_r.fault_flags))
        else $error("read data wrong in the cycle after the strobe");

    // Per-source checks; each looks only one cycle ahead, so a later clear never trips them.
    chk_zone4_never_masked: assert property (
        zone_limit_event[3] |=> q_r.thermal_flags[3])
        else $error("zone four event did not set its flag");

    chk_zone2_opt_mask: assert property (
        (deep_sleep && q_r.mask_thermal[1] && !q_r.thermal_flags[1] && !reg_wr_en)
        |=> !q_r.thermal_flags[1])
        else $error("masked zone two event set its flag");

    chk_analog_low_sets: assert property (
        (analog_input_window_event[0] && !deep_sleep) |=> q_r.analog_low_flags[0])
        else $error("analog one event lost while awake");

    chk_analog_high_sets: assert property (
        (analog_input_window_event[8] && !deep_sleep) |=> q_r.analog_high_flags[0])
        else $error("analog nine event lost while awake");

    chk_analog15_deep_block: assert property (
        (deep_sleep && !q_r.analog_high_flags[6] && !reg_wr_en) |=> !q_r.analog_high_flags[6])
        else $error("analog fifteen flag set in deep sleep");

    chk_analog12_unmasked: assert property (
        (deep_sleep && !q_r.mask_analog_high[3] && analog_input_window_event[11])
        |=> q_r.analog_high_flags[3])
        else $error("unmasked analog twelve event lost in deep sleep");

    chk_analog12_opt_mask: assert property (
        (deep_sleep && q_r.mask_analog_high[3] && !q_r.analog_high_flags[3] && !reg_wr_en)
        |=> !q_r.analog_high_flags[3])
        else $error("masked analog twelve event set its flag");

    chk_termination_block: assert property (
        (deep_sleep && q_r.fault_flags[3:2] == 2'b00 && !reg_wr_en) |=> q_r.fault_flags[3:2] == 2'b00)
        else $error("termination flag set in deep sleep");

    chk_core_two_sets: assert property (
        (core_voltage_two_mismatch && !deep_sleep) |=> q_r.fault_flags[5])
        else $error("core voltage two mismatch not flagged");

    chk_diode_one_unmasked: assert property (
        (deep_sleep && !q_r.mask_fault[6] && diode_one_fault) |=> q_r.fault_flags[6])
        else $error("unmasked diode one fault lost in deep sleep");

    chk_diode_two_opt_mask: assert property (
        (deep_sleep && q_r.mask_fault[7] && !q_r.fault_flags[7] && !reg_wr_en)
        |=> !q_r.fault_flags[7])
        else $error("masked diode two fault set its flag");

    chk_flag_sticky: assert property (
        (q_r.fault_flags[6] && !wr_fault) |=> q_r.fault_flags[6])
        else $error("flag dropped without a clear");

    chk_read_idle_zero: assert property (
        !reg_rd_en |=> reg_rd_data == 8'h00)
        else $error("read data stood without a read strobe");

    cov_zone1_flag: cover property (zone_limit_event[0] ##1 q_r.thermal_flags[0]);
    cov_deep_clear: cover property (deep_sleep && wr_fault && q_r.fault_flags != 8'h00);
    cov_summary_rise: cover property (!host_error_summary ##1 host_error_summary);
    cov_opt_unmasked_deep: cover property (deep_sleep && !q_r.mask_fault[6]
        && diode_one_fault ##1 q_r.fault_flags[6]);

endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking testbench of the host error status bank.
`timescale 1ns/100ps
`default_nettype none
module tb
    import hesb_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus rows and bench signals
    // ------------------------------------------------------------
    // Each row: sleep state, three masks, event vector, expected flags {48,49,4a,4b}.
    typedef struct packed {
        logic [1:0] sleep;
        logic [7:0] mth;
        logic [7:0] mah;
        logic [7:0] mft;
        logic [27:0] ev;
        logic [31:0] exp;
    } hesb_row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_rd_data;
    logic host_error_summary;
    // Event bus: zones[27:24], hot one, hot two, analog[21:6], term one, term two, core one, core two, diode one, diode two.
    logic [27:0] ev_bus = 28'h0000000;
    int fail_count = 0;
    int samples_checked = 0;
    hesb_row_s rows [7];

    // The clock toggles every 10 ns, a period of 20 ns.
    always #10 clk = ~clk;

    hesb_host_error_status_bank i_dut (
        .clk(clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data),
        .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data),
        .zone_limit_event(ev_bus[27:24]),
        .regulator_one_hot_input(ev_bus[23]),
        .regulator_two_hot_input(ev_bus[22]),
        .analog_input_window_event(ev_bus[21:6]),
        .termination_one_input(ev_bus[5]),
        .termination_two_input(ev_bus[4]),
        .core_voltage_one_mismatch(ev_bus[3]),
        .core_voltage_two_mismatch(ev_bus[2]),
        .diode_one_fault(ev_bus[1]),
        .diode_two_fault(ev_bus[0]),
        .host_error_summary(host_error_summary)
    );

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // A write is taken at the edge after the strobe is raised.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the taking edge, so sample just after it.
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        #1;
        check(reg_rd_data, exp);
    endtask

    task automatic pulse(input logic [27:0] e);
        @(posedge clk);
        ev_bus <= e;
        @(posedge clk);
        ev_bus <= 28'h0000000;
        #1;
    endtask

    task automatic complete_run();
        $display("samples_checked=%0d fail_count=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The whole run needs well under a thousand cycles; this limit catches a hang.
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rows[0] = '{SLEEP_S0, 8'h00, 8'h00, 8'h00, 28'hfffffff, 32'h3fff_fffc};
        rows[1] = '{SLEEP_S3, 8'h00, 8'h00, 8'h00, 28'hfffffff, 32'h0f00_b8c0};
        rows[2] = '{SLEEP_S45, 8'hff, 8'hff, 8'hff, 28'hfffffff, 32'h0c00_8000};
        rows[3] = '{SLEEP_S1, 8'hff, 8'hff, 8'hff, 28'hfffffff, 32'h3fff_fffc};
        rows[4] = '{SLEEP_S45, 8'h00, 8'h00, 8'h00, 28'hfffffff, 32'h0f00_b8c0};
        rows[5] = '{SLEEP_S0, 8'h00, 8'h00, 8'h00, {4'h1, 2'b01, 16'h8001, 6'b011001}, 32'h2101_8098};
        rows[6] = '{SLEEP_S0, 8'h00, 8'h00, 8'h00, {4'h8, 2'b10, 16'h0180, 6'b100110}, 32'h1880_0164};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, and an unmapped place that must read zero.
        rdchk(8'h50, 8'h00);
        for (int a = 8'h48; a <= 8'h4b; a++) begin
            rdchk(a[7:0], FLAGS_RESET);
        end
        for (int a = 8'h60; a <= 8'h64; a++) begin
            rdchk(a[7:0], MASK_RESET);
        end
        // Table rows: program sleep state and masks, fire one event pulse, read, then clear.
        for (int i = 0; i < 7; i++) begin
            wr(OFF_SLEEP_STATE, {6'h00, rows[i].sleep});
            wr(OFF_MASK_THERMAL, rows[i].mth);
            wr(OFF_MASK_ANALOG_HIGH, rows[i].mah);
            wr(OFF_MASK_FAULT, rows[i].mft);
            pulse(rows[i].ev);
            check({7'h00, host_error_summary}, {7'h00, |rows[i].exp});
            rdchk(OFF_THERMAL_REG, rows[i].exp[31:24]);
            rdchk(OFF_ANALOG_LOW, rows[i].exp[23:16]);
            rdchk(OFF_ANALOG_HIGH, rows[i].exp[15:8]);
            rdchk(OFF_FAULT, rows[i].exp[7:0]);
            for (int a = 8'h48; a <= 8'h4b; a++) begin
                wr(a[7:0], 8'hff);
            end
            #1;
            check({7'h00, host_error_summary}, 8'h00);
        end
        // Control registers keep only their implemented bits.
        wr(OFF_SLEEP_STATE, 8'hff);
        rdchk(OFF_SLEEP_STATE, 8'h03);
        wr(OFF_MASK_THERMAL, 8'hff);
        rdchk(OFF_MASK_THERMAL, 8'h03);
        wr(OFF_MASK_ANALOG_HIGH, 8'hff);
        rdchk(OFF_MASK_ANALOG_HIGH, 8'h38);
        wr(OFF_MASK_FAULT, 8'hff);
        rdchk(OFF_MASK_FAULT, 8'hc0);
        wr(8'h50, 8'hff);
        rdchk(8'h50, 8'h00);
        wr(OFF_SLEEP_STATE, {6'h00, SLEEP_S0});
        // A clear while the zone three condition persists must fail.
        @(posedge clk);
        ev_bus <= 28'h4000000;
        wr(OFF_THERMAL_REG, 8'hff);
        rdchk(OFF_THERMAL_REG, 8'h04);
        @(posedge clk);
        #1;
        check(reg_rd_data, 8'h00);
        @(posedge clk);
        ev_bus <= 28'h0000000;
        rdchk(OFF_THERMAL_REG, 8'h04);
        wr(OFF_THERMAL_REG, 8'h00);
        rdchk(OFF_THERMAL_REG, 8'h04);
        rdchk(OFF_GLOBAL_STATUS, GSTAT_HOST_ERR);
        // A one-cycle event on the very edge of a clear must win.
        @(posedge clk);
        reg_addr <= OFF_THERMAL_REG;
        reg_wr_data <= 8'h04;
        reg_wr_en <= 1'b1;
        ev_bus <= 28'h4000000;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        ev_bus <= 28'h0000000;
        rdchk(OFF_THERMAL_REG, 8'h04);
        wr(OFF_THERMAL_REG, 8'h04);
        rdchk(OFF_THERMAL_REG, 8'h00);
        rdchk(OFF_GLOBAL_STATUS, 8'h00);
        // A reset in mid-run wipes a set flag and the sleep state.
        wr(OFF_SLEEP_STATE, {6'h00, SLEEP_S3});
        pulse(28'h8000000);
        check({7'h00, host_error_summary}, 8'h01);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({7'h00, host_error_summary}, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        rdchk(OFF_THERMAL_REG, FLAGS_RESET);
        rdchk(OFF_SLEEP_STATE, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
